// [lcdc_consts.svh]
// Constants of the LCD driver control block: register offsets, field positions, reset values
// Assumes inclusion from package and modules by bare name
`ifndef LCDC_CONSTS_SVH
`define LCDC_CONSTS_SVH

// Register offsets, printed offsets are not all multiples of four, so these are indices
`define LCDC_IDX_POWER_DUTY     16'hFF60
`define LCDC_IDX_DISPLAY        16'hFF61
`define LCDC_IDX_CONTRAST       16'hFF62
// Byte address is four times the index
`define LCDC_ADDR_W             18

// Field positions in lcd_power_duty_ctrl
`define LCDC_SUPPLY_ON_POS      0
`define LCDC_REF_SEL_POS        1
`define LCDC_DUTY_LOW_POS       2
`define LCDC_DUTY_HIGH_POS      3
// Field positions in lcd_display_ctrl
`define LCDC_PAGE_POS           0
`define LCDC_ALL_ON_POS         1
`define LCDC_ALL_OFF_POS        2
`define LCDC_EXP_EN_POS         3

// Reset values
`define LCDC_POWER_DUTY_RST     4'h0
`define LCDC_DISPLAY_RST        4'h4

// Settling time of the drive voltages after power on
`define LCDC_SETTLE_MS          100
`define LCDC_CLK_KHZ            200000
`define LCDC_SETTLE_CYC         (`LCDC_SETTLE_MS * `LCDC_CLK_KHZ)

// Row counts per duty
`define LCDC_ROWS_DUTY8         5'h08
`define LCDC_ROWS_DUTY16        5'h10
`define LCDC_ROWS_DUTY17        5'h11

// Read data for an unmapped address
`define LCDC_UNMAPPED_DATA      32'h0000_0000

`endif

// [lcdc_pkg.sv]
// Types of the LCD driver control block
// Assumes lcdc_consts.svh is on the include path
`include "lcdc_consts.svh"
package lcdc_pkg;

	typedef enum logic [1:0] {
		LCDC_DUTY_17 = 2'h0,
		LCDC_DUTY_16 = 2'h1,
		LCDC_DUTY_8  = 2'h3
	} lcdc_duty_t;

	typedef enum logic [1:0] {
		LCDC_SEG_NORMAL = 2'h0,
		LCDC_SEG_ON     = 2'h1,
		LCDC_SEG_OFF    = 2'h3
	} lcdc_seg_mode_t;

	typedef enum logic [1:0] {
		LCDC_BUS_IDLE = 2'h0,
		LCDC_BUS_ACK  = 2'h1
	} lcdc_bus_st_t;

endpackage

// [lcdc_bus_slave.sv]
// Avalon-MM slave front end of the LCD driver control registers
// Assumes one clock, synchronous active-high reset, word addressed by byte address
`timescale 1ns/100ps
`include "lcdc_consts.svh"
module lcdc_bus_slave
	import lcdc_pkg::*;
(
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      reset,
	// Avalon-MM
	input  wire logic [`LCDC_ADDR_W-1:0]   address,
	input  wire logic                      read,
	input  wire logic                      write,
	input  wire logic [31:0]               writedata,
	input  wire logic [3:0]                byteenable,
	output logic      [31:0]               readdata,
	output logic                           waitrequest,
	// Register side
	output logic                           wr_power_duty,
	output logic                           wr_display,
	output logic                           wr_contrast,
	output logic      [3:0]                wr_data,
	input  wire logic [3:0]                rd_power_duty,
	input  wire logic [3:0]                rd_display,
	input  wire logic [3:0]                rd_contrast
);
	import lcdc_pkg::*;

	typedef struct packed {
		lcdc_bus_st_t st;
		logic [31:0]  rdata;
	} lcdc_bus_state_t;

	lcdc_bus_state_t s_r;
	lcdc_bus_state_t s_nxt;

	function automatic logic hit(input logic [`LCDC_ADDR_W-1:0] a, input logic [15:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction

	logic take;
	logic lane0;

	// One wait cycle per access so read data always comes from a flip-flop
	assign take        = (read | write) && (s_r.st == LCDC_BUS_IDLE);
	assign waitrequest = (read | write) && (s_r.st != LCDC_BUS_ACK);
	assign readdata    = s_r.rdata;
	assign lane0       = byteenable[0];
	assign wr_data     = writedata[3:0];
	assign wr_power_duty = write && take && lane0 && hit(address, `LCDC_IDX_POWER_DUTY);
	assign wr_display    = write && take && lane0 && hit(address, `LCDC_IDX_DISPLAY);
	assign wr_contrast   = write && take && lane0 && hit(address, `LCDC_IDX_CONTRAST);

	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			LCDC_BUS_IDLE: begin
				if (read | write) begin
					s_nxt.st = LCDC_BUS_ACK;
					if (hit(address, `LCDC_IDX_POWER_DUTY))
						s_nxt.rdata = {28'h0000000, rd_power_duty};
					else if (hit(address, `LCDC_IDX_DISPLAY))
						s_nxt.rdata = {28'h0000000, rd_display};
					else if (hit(address, `LCDC_IDX_CONTRAST))
						s_nxt.rdata = {28'h0000000, rd_contrast};
					else
						s_nxt.rdata = `LCDC_UNMAPPED_DATA;
				end
			end
			LCDC_BUS_ACK: begin
				s_nxt.st = LCDC_BUS_IDLE;
			end
			default: begin
				s_nxt.st = LCDC_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_r <= '{st: LCDC_BUS_IDLE, rdata: 32'h0000_0000};
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule // lcdc_bus_slave

// [lcdc_settle_timer.sv]
// Counts the drive-voltage settling time after the supply is switched on
// Assumes one clock, synchronous active-high reset
`timescale 1ns/100ps
`include "lcdc_consts.svh"
module lcdc_settle_timer
	import lcdc_pkg::*;
#(
	parameter int unsigned SETTLE_CYC = `LCDC_SETTLE_CYC
)(
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Control and status
	input  wire logic supply_on,
	output logic      settled
);
	import lcdc_pkg::*;

	typedef struct packed {
		logic [24:0] cnt;
		logic        done;
	} lcdc_tmr_state_t;

	lcdc_tmr_state_t s_r;
	lcdc_tmr_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (!supply_on) begin
			s_nxt.cnt  = 25'h0000000;
			s_nxt.done = 1'b0;
		end else if (!s_r.done) begin
			if (s_r.cnt >= 25'(SETTLE_CYC - 1))
				s_nxt.done = 1'b1;
			else
				s_nxt.cnt = s_r.cnt + 25'h0000001;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_r <= '{cnt: 25'h0000000, done: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign settled = s_r.done;

endmodule // lcdc_settle_timer

// [lcdc_ctrl.sv]
// LCD driver control: three 4-bit control registers over Avalon-MM and the decoded controls
// Assumes one 200 MHz clock, synchronous active-high reset, analog and waveform logic outside
//
// Operation
// - Writing one to supply-on enables the voltage generator; reads back.
// - Writing zero turns generator off and grounds all drive voltages.
// - Reset clears supply-on and sets all-off, display starts blank.
// - Reference select: one picks second level, zero first; resets zero.
// - Duty: high bit one gives 1/8, 01 gives 1/16, 00 gives 1/17.
// - All-on forces ON waveform on all columns, memory untouched.
// - All-off forces OFF waveform on all columns, memory untouched.
// - All-on wins when both all-on and all-off are set.
// - All-off is one after reset.
// - At 1/8 duty page select picks second or first memory half.
// - At 1/16 or 1/17 page select is only a storage bit.
// - Contrast code sets 16 drive levels, light to dark; reads back.
// - Contrast code not reset; software writes it and display memory.
// - With external supply option contrast code has no effect.
// - Expansion enable gates signals to external driver; resets zero.
// - Display memory bit one drives dot on, zero drives it off.
`timescale 1ns/100ps
`include "lcdc_consts.svh"
module lcdc_ctrl
	import lcdc_pkg::*;
#(
	parameter int unsigned SETTLE_CYC   = `LCDC_SETTLE_CYC,
	parameter bit          EXT_SUPPLY   = 1'b0
)(
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset,
	// Avalon-MM slave
	input  wire logic [`LCDC_ADDR_W-1:0] address,
	input  wire logic                    read,
	input  wire logic                    write,
	input  wire logic [31:0]             writedata,
	input  wire logic [3:0]              byteenable,
	output logic      [31:0]             readdata,
	output logic                         waitrequest,
	// Supply generator control
	output logic                         supply_on_bit,
	output logic                         drive_grounded,
	output logic                         supply_settled,
	output logic                         reference_select_bit,
	output logic      [3:0]              contrast_drive,
	// Duty and row selection
	output lcdc_pkg::lcdc_duty_t         duty,
	output logic      [4:0]              row_count,
	output logic                         page_high,
	// Column drive
	output lcdc_pkg::lcdc_seg_mode_t     seg_mode,
	input  wire logic                    dot_data,
	output logic                         column_dot_on,
	// Expansion driver
	output logic                         expansion_driver_enable
);
	import lcdc_pkg::*;

	typedef struct packed {
		logic [3:0] power_duty;
		logic [3:0] display;
		logic       dot_on;
	} lcdc_ctrl_state_t;

	lcdc_ctrl_state_t s_r;
	lcdc_ctrl_state_t s_nxt;
	// Contrast is kept outside the reset struct since it has no reset value
	logic [3:0] contrast_r;

	logic       wr_power_duty;
	logic       wr_display;
	logic       wr_contrast;
	logic [3:0] wr_data;

	lcdc_bus_slave u_bus (
		.clk           (clk),
		.reset         (reset),
		.address       (address),
		.read          (read),
		.write         (write),
		.writedata     (writedata),
		.byteenable    (byteenable),
		.readdata      (readdata),
		.waitrequest   (waitrequest),
		.wr_power_duty (wr_power_duty),
		.wr_display    (wr_display),
		.wr_contrast   (wr_contrast),
		.wr_data       (wr_data),
		.rd_power_duty (s_r.power_duty),
		.rd_display    (s_r.display),
		.rd_contrast   (contrast_r)
	);

	// Settling status only, the wait itself is software's job
	lcdc_settle_timer #(
		.SETTLE_CYC (SETTLE_CYC)
	) u_settle (
		.clk       (clk),
		.reset     (reset),
		.supply_on (s_r.power_duty[`LCDC_SUPPLY_ON_POS]),
		.settled   (supply_settled)
	);

	function automatic lcdc_duty_t decode_duty(input logic hi, input logic lo);
		if (hi)
			decode_duty = LCDC_DUTY_8;
		else if (lo)
			decode_duty = LCDC_DUTY_16;
		else
			decode_duty = LCDC_DUTY_17;
	endfunction

	function automatic lcdc_seg_mode_t decode_seg(input logic on, input logic off);
		if (on)
			decode_seg = LCDC_SEG_ON;
		else if (off)
			decode_seg = LCDC_SEG_OFF;
		else
			decode_seg = LCDC_SEG_NORMAL;
	endfunction

	lcdc_seg_mode_t seg_nxt;

	always_comb begin
		s_nxt = s_r;
		if (wr_power_duty)
			s_nxt.power_duty = wr_data;
		if (wr_display)
			s_nxt.display = wr_data;
		seg_nxt = decode_seg(s_nxt.display[`LCDC_ALL_ON_POS], s_nxt.display[`LCDC_ALL_OFF_POS]);
		case (seg_nxt)
			LCDC_SEG_ON:     s_nxt.dot_on = 1'b1;
			LCDC_SEG_OFF:    s_nxt.dot_on = 1'b0;
			LCDC_SEG_NORMAL: s_nxt.dot_on = dot_data;
			default:         s_nxt.dot_on = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_r <= '{power_duty: `LCDC_POWER_DUTY_RST, display: `LCDC_DISPLAY_RST,
				dot_on: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// No reset branch: contents are undefined until software writes them
	always_ff @(posedge clk) begin
		if (wr_contrast)
			contrast_r <= wr_data;
	end

	assign supply_on_bit        = s_r.power_duty[`LCDC_SUPPLY_ON_POS];
	assign drive_grounded       = !s_r.power_duty[`LCDC_SUPPLY_ON_POS];
	assign reference_select_bit = s_r.power_duty[`LCDC_REF_SEL_POS];
	// External supply ignores the code; hold it at zero rather than pass a meaningless value
	assign contrast_drive       = EXT_SUPPLY ? 4'h0 : contrast_r;
	assign duty = decode_duty(s_r.power_duty[`LCDC_DUTY_HIGH_POS],
		s_r.power_duty[`LCDC_DUTY_LOW_POS]);

	always_comb begin
		case (duty)
			LCDC_DUTY_8:  row_count = `LCDC_ROWS_DUTY8;
			LCDC_DUTY_16: row_count = `LCDC_ROWS_DUTY16;
			LCDC_DUTY_17: row_count = `LCDC_ROWS_DUTY17;
			default:      row_count = `LCDC_ROWS_DUTY17;
		endcase
	end

	// Page only moves the window at 1/8 duty; otherwise the bit is plain storage
	assign page_high = (duty == LCDC_DUTY_8) && s_r.display[`LCDC_PAGE_POS];
	assign seg_mode  = decode_seg(s_r.display[`LCDC_ALL_ON_POS],
		s_r.display[`LCDC_ALL_OFF_POS]);
	assign column_dot_on           = s_r.dot_on;
	assign expansion_driver_enable = s_r.display[`LCDC_EXP_EN_POS];

endmodule // lcdc_ctrl

// [lcdc_ctrl_properties.sv]
// Concurrent checks on the ports of the LCD driver control block
// Assumes one clock, synchronous active-high reset, bound into lcdc_ctrl
`timescale 1ns/100ps
module lcdc_ctrl_properties
	import lcdc_pkg::*;
#(
	parameter int unsigned SETTLE_CYC = 10
)(
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 reset,
	// Bus
	input wire logic                 read,
	input wire logic                 write,
	input wire logic [31:0]          readdata,
	input wire logic                 waitrequest,
	// Controls
	input wire logic                 supply_on_bit,
	input wire logic                 drive_grounded,
	input wire logic                 supply_settled,
	input wire lcdc_pkg::lcdc_duty_t duty,
	input wire logic [4:0]           row_count,
	input wire logic                 page_high,
	input wire lcdc_pkg::lcdc_seg_mode_t seg_mode,
	input wire logic                 dot_data,
	input wire logic                 column_dot_on
);
	logic [31:0] on_cnt_r;

	// Cycles the supply has been on, saturating so a long run cannot wrap
	always_ff @(posedge clk) begin
		if (reset || !supply_on_bit)
			on_cnt_r <= 32'h0;
		else if (on_cnt_r != 32'hFFFF_FFFF)
			on_cnt_r <= on_cnt_r + 32'h1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_ground_level: assert property (drive_grounded == !supply_on_bit)
		else $error("drive ground does not follow supply bit");
	a_all_on_wins: assert property (seg_mode == LCDC_SEG_ON |-> column_dot_on)
		else $error("dot not lit under all-on");
	a_all_off: assert property (seg_mode == LCDC_SEG_OFF |-> !column_dot_on)
		else $error("dot lit under all-off");
	a_dot_follow: assert property (seg_mode == LCDC_SEG_NORMAL |-> column_dot_on == $past(dot_data))
		else $error("dot does not follow memory bit");
	a_duty_rows: assert property (row_count == (duty == LCDC_DUTY_8 ? 5'h08 :
			duty == LCDC_DUTY_16 ? 5'h10 : 5'h11))
		else $error("row count does not match duty");
	a_page_gate: assert property (page_high |-> duty == LCDC_DUTY_8)
		else $error("page select active outside eighth duty");
	a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("access not answered after one wait cycle");
	a_idle_nowait: assert property (!(read || write) |-> !waitrequest)
		else $error("wait raised without a request");
	a_read_upper: assert property (read && !waitrequest |-> readdata[31:4] == 28'h0)
		else $error("unused read bits not zero");
	a_settle_early: assert property (supply_settled |-> on_cnt_r >= SETTLE_CYC - 1)
		else $error("settled flag too early");
	a_settle_late: assert property (on_cnt_r >= SETTLE_CYC + 2 |-> supply_settled)
		else $error("settled flag too late");
endmodule // lcdc_ctrl_properties

bind lcdc_ctrl lcdc_ctrl_properties #(.SETTLE_CYC(SETTLE_CYC)) lcdc_ctrl_properties_i (.*);

// [lcdc_panel_model.sv]
// Panel side model: a small display memory feeding one dot bit per cycle
// Assumes one clock; row_count from the controller bounds the scan
`timescale 1ns/100ps
module lcdc_panel_model (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// Scan from the controller
	input wire logic [4:0]  row_count,
	input wire logic        page_high,
	input wire logic        column_dot_on,
	// Memory bit back, and lit dots seen
	output logic            dot_data,
	output logic [15:0]     lit_count
);
	logic [16:0] mem_lo_r;
	logic [16:0] mem_hi_r;
	logic [4:0]  row_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			// Reset loads fixed patterns into both memory halves; nothing writes them afterwards
			mem_lo_r <= 17'h0A5C3;
			mem_hi_r <= 17'h1335A;
			row_r <= 5'h00;
			lit_count <= 16'h0000;
		end else begin
			// Scan never leaves the populated rows
			row_r <= (row_r + 5'h01 >= row_count) ? 5'h00 : row_r + 5'h01;
			lit_count <= lit_count + {15'h0, column_dot_on};
		end
	end

	assign dot_data = page_high ? mem_hi_r[row_r] : mem_lo_r[row_r];
endmodule // lcdc_panel_model

// [tb.sv]
// Self-checking testbench of the LCD driver control registers
// Assumes package, header, checker and panel model are compiled first
`timescale 1ns/100ps
module tb;
	import lcdc_pkg::*;
	localparam int unsigned SETTLE = 10;
	localparam logic [17:0] A_PD = 18'h3FD80;
	localparam logic [17:0] A_DC = 18'h3FD84;
	localparam logic [17:0] A_CL = 18'h3FD88;
	logic clk, reset, read, write, waitrequest, dot_data, column_dot_on;
	logic supply_on_bit, drive_grounded, supply_settled, reference_select_bit;
	logic page_high, expansion_driver_enable;
	logic [17:0] address;
	logic [31:0] writedata, readdata, rd;
	logic [3:0] byteenable, contrast_drive;
	logic [4:0] row_count;
	logic [15:0] lit_count, lit0;
	lcdc_duty_t duty;
	lcdc_seg_mode_t seg_mode;
	logic [3:0] contrast_ext;
	int failures, total_checks;

	lcdc_ctrl #(.SETTLE_CYC(SETTLE), .EXT_SUPPLY(1'b0)) lcdc_ctrl_i (.*);
	// Copy built for external supply; it shares the bus, only its contrast output is watched
	lcdc_ctrl #(.SETTLE_CYC(SETTLE), .EXT_SUPPLY(1'b1)) lcdc_ctrl_ext_i (
		.clk                     (clk),
		.reset                   (reset),
		.address                 (address),
		.read                    (read),
		.write                   (write),
		.writedata               (writedata),
		.byteenable              (byteenable),
		.readdata                (),
		.waitrequest             (),
		.supply_on_bit           (),
		.drive_grounded          (),
		.supply_settled          (),
		.reference_select_bit    (),
		.contrast_drive          (contrast_ext),
		.duty                    (),
		.row_count               (),
		.page_high               (),
		.seg_mode                (),
		.dot_data                (dot_data),
		.column_dot_on           (),
		.expansion_driver_enable ()
	);
	lcdc_panel_model lcdc_panel_model_i (.*);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Request held until the rising edge that samples waitrequest low; a hang is the watchdog's
	task automatic access(input logic wr, input logic [17:0] a, input logic [31:0] d,
			input logic [3:0] be);
		@(posedge clk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		byteenable <= be;
		do begin
			@(posedge clk);
		end while (waitrequest);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [17:0] a, input logic [31:0] d);
		access(1'b1, a, d, 4'hF);
	endtask

	task automatic rdchk(input logic [17:0] a, input logic [3:0] e);
		access(1'b0, a, 32'h0, 4'hF);
		chk(rd, {28'h0, e});
	endtask

	task automatic do_reset(input int cyc);
		reset <= 1'b1;
		repeat (cyc) @(posedge clk);
		reset <= 1'b0;
	endtask

	task automatic chk_defaults();
		rdchk(A_PD, 4'h0);
		rdchk(A_DC, 4'h4);
		chk(drive_grounded, 1'b1);
		chk(seg_mode, LCDC_SEG_OFF);
		chk(expansion_driver_enable, 1'b0);
	endtask

	// Lit dots seen by the panel over eight cycles
	task automatic lit_chk(input logic [31:0] d, input logic [15:0] n);
		wr(A_DC, d);
		@(negedge clk);
		lit0 = lit_count;
		repeat (8) @(negedge clk);
		chk(lit_count, lit0 + n);
	endtask

	task automatic conclude();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		read = 1'b0;
		write = 1'b0;
		address = 18'h0;
		writedata = 32'h0;
		byteenable = 4'h0;
		do_reset(16);
		chk_defaults();
		for (int v = 0; v < 16; v++) begin
			wr(A_CL, 32'hFFFF_FFF0 | v);
			rdchk(A_CL, v[3:0]);
			chk(contrast_drive, v);
			chk(contrast_ext, 4'h0);
		end
		// Lane zero off leaves contrast alone; unmapped places read back zero
		access(1'b1, A_CL, 32'h5, 4'hE);
		rdchk(A_CL, 4'hF);
		wr(18'h3FD8C, 32'hA);
		rdchk(18'h3FD8C, 4'h0);
		for (int v = 0; v < 16; v++) begin
			wr(A_PD, v);
			rdchk(A_PD, v[3:0]);
			chk(supply_on_bit, v[0]);
			chk(drive_grounded, !v[0]);
			chk(reference_select_bit, v[1]);
			chk(duty, v[3] ? 2'h3 : {1'b0, v[2]});
			chk(row_count, v[3] ? 5'h08 : v[2] ? 5'h10 : 5'h11);
		end
		for (int p = 0; p < 2; p++) begin
			wr(A_PD, p ? 32'h5 : 32'h8);
			for (int v = 0; v < 16; v++) begin
				wr(A_DC, v);
				rdchk(A_DC, v[3:0]);
				chk(page_high, v[0] && !p);
				chk(seg_mode, v[1] ? LCDC_SEG_ON : v[2] ? LCDC_SEG_OFF : LCDC_SEG_NORMAL);
				chk(expansion_driver_enable, v[3]);
			end
		end
		lit_chk(32'h6, 16'h8);
		lit_chk(32'h4, 16'h0);
		// Supply was left on by the display scenario; switch it off so the count restarts
		wr(A_PD, 32'h0);
		wr(A_PD, 32'h1);
		chk(supply_settled, 1'b0);
		repeat (SETTLE + 4) @(posedge clk);
		chk(supply_settled, 1'b1);
		wr(A_PD, 32'h0);
		@(negedge clk);
		chk(supply_settled, 1'b0);
		wr(A_DC, 32'h9);
		wr(A_PD, 32'hF);
		do_reset(2);
		chk_defaults();
		conclude();
	end

	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		conclude();
	end
endmodule // tb
